// *** include/ris_consts.vh ***
// Constants for the remappable input selector bank.
// Included by rtl/ris_input_selectors.v; definitions only.
`ifndef RIS_CONSTS_VH
`define RIS_CONSTS_VH

// Byte offsets on the register bus, one aligned word each
`define RIS_ADDR_IRQ2        8'h00
`define RIS_ADDR_TIMER_CLK   8'h04
`define RIS_ADDR_CAPTURE_12  8'h08
`define RIS_ADDR_CAPTURE_78  8'h0C
`define RIS_ADDR_CMP_FAULT   8'h10
`define RIS_ADDR_PWM1_FAULT  8'h14
`define RIS_ADDR_PWM2_FAULT  8'h18
`define RIS_ADDR_QUADRATURE  8'h1C
`define RIS_ADDR_LOCK        8'h20
`define RIS_ADDR_STATUS      8'h24

// Field positions
`define RIS_LO_MSB           4
`define RIS_LO_LSB           0
`define RIS_HI_MSB           12
`define RIS_HI_LSB           8

// Field values
`define RIS_SEL_RESET        5'h1F
`define RIS_SEL_GROUND       5'h1F
`define RIS_SEL_MAX_PIN      5'h19
`define RIS_LOCK_RESET       1'h0

`endif

// *** rtl/ris_input_selectors.v ***
// Remappable input selector bank: eight selector registers on a classic
// Wishbone slave, steering remappable pins onto peripheral inputs.
// Assumes one clock, synchronous pins and a system reset controller that
// acts on the mismatch request output.
// Functional notes
// R1: Bits 4-0 of the interrupt selector pick the pin for external interrupt two.
// R2: Timer clock selector bits 12-8 pick the timer 3 external clock pin.
// R3: Timer clock selector bits 4-0 pick the timer 2 external clock pin.
// R4: Capture selector one: bits 12-8 feed capture 2, bits 4-0 capture 1.
// R5: Capture selector two: bits 12-8 feed capture 8, bits 4-0 capture 7.
// R6: Compare fault input comes from the pin chosen by its bits 4-0.
// R7: PWM1 fault input comes from its selector bits 4-0; upper bits unused.
// R8: PWM2 fault input comes from its own selector bits 4-0; upper unused.
// R9: Quadrature selector bits 12-8 pick the encoder phase B pin.
// R10: Quadrature selector bits 4-0 pick the encoder phase A pin.
// R11: An all-ones field ties its peripheral input to ground.
// R12: Code 11001 selects remappable pin 25, the highest pin.
// R13: Codes map straight to pin numbers, zero selects pin zero.
// R14: Unimplemented bits of two-field selectors read zero.
// R15: Every implemented selector bit resets to one, grounding each input.
// R16: Single-field selectors implement only bits 4-0; others read zero.
// R17: With the lock set, selector writes are acknowledged but ignored.
// R18: Software runs the unlock key sequence before changing the lock.
// R19: Shadow copies watch the selectors; any difference requests a reset.
// R20: Codes above pin 25 but below all ones also ground the input.
`include "ris_consts.vh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// One pin selector: decodes a 5-bit code onto the pin bus

module ris_pin_mux #(
    parameter NUM_PINS = 26
) (
    input  wire [4:0]          sel_in,   // Selector code
    input  wire [NUM_PINS-1:0] pins_in,  // Remappable pins
    output wire                peri_out  // Peripheral input
);
    // Anything past the last pin, all ones included, grounds the input
    assign peri_out = ({27'h0, sel_in} < NUM_PINS) ? pins_in[sel_in] : 1'b0; // R11 R12 R13 R20
endmodule // ris_pin_mux

////////////////////////////////////////////////////////////////////////////////

module ris_input_selectors #(
    parameter NUM_PINS = 26
) (
    input  wire                clk_sys_in,          // System clock
    input  wire                rst_n_in,            // Sync reset, active low
    input  wire                wb_cyc_in,           // Wishbone cycle
    input  wire                wb_stb_in,           // Wishbone strobe
    input  wire                wb_we_in,            // Write enable
    input  wire [7:0]          wb_adr_in,           // Byte address
    input  wire [3:0]          wb_sel_in,           // Byte lane selects
    input  wire [31:0]         wb_dat_in,           // Write data
    output reg  [31:0]         wb_dat_out,          // Read data
    output reg                 wb_ack_out,          // Acknowledge
    input  wire [NUM_PINS-1:0] remappable_pin_in,   // Remappable pins
    input  wire                upset_in,            // Fault injection into a selector bit
    output wire                external_irq_two_out, // Interrupt two input
    output wire                timer2_ext_clock_out, // Timer 2 clock
    output wire                timer3_ext_clock_out, // Timer 3 clock
    output wire                capture1_out,         // Capture 1
    output wire                capture2_out,         // Capture 2
    output wire                capture7_out,         // Capture 7
    output wire                capture8_out,         // Capture 8
    output wire                compare_fault_input_out, // Compare fault
    output wire                pwm1_fault_input_out, // PWM1 fault
    output wire                pwm2_fault_input_out, // PWM2 fault
    output wire                encoder_phase_a_out,  // Encoder A
    output wire                encoder_phase_b_out,  // Encoder B
    output reg                 mismatch_reset_out    // Mismatch reset request
);

    ////////////////////////////////////////////////////////////////////////////
    // Selector fields, one 5-bit entry per peripheral input

    localparam NFIELD = 12;
    localparam F_IRQ2 = 0;
    localparam F_T2   = 1;
    localparam F_T3   = 2;
    localparam F_IC1  = 3;
    localparam F_IC2  = 4;
    localparam F_IC7  = 5;
    localparam F_IC8  = 6;
    localparam F_OCF  = 7;
    localparam F_PF1  = 8;
    localparam F_PF2  = 9;
    localparam F_QEA  = 10;
    localparam F_QEB  = 11;

    reg  [4:0] sel_field [0:NFIELD-1];
    reg  [4:0] shadow    [0:NFIELD-1];
    reg        pin_select_lock;
    reg  [4:0] next_field [0:NFIELD-1];
    wire [NFIELD-1:0] peri;

    wire req      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire wr       = req & wb_we_in;
    wire lane0    = wb_sel_in[0];
    wire lane1    = wb_sel_in[1];
    wire sel_wr   = wr & ~pin_select_lock; // R17
    wire [4:0] lo = wb_dat_in[`RIS_LO_MSB:`RIS_LO_LSB];
    wire [4:0] hi = wb_dat_in[`RIS_HI_MSB:`RIS_HI_LSB];

    // Next value of every field from the current write, if any
    integer k;
    always @* begin
        for (k = 0; k < NFIELD; k = k + 1) begin
            next_field[k] = sel_field[k];
        end
        if (sel_wr && lane0) begin
            case (wb_adr_in)
                `RIS_ADDR_IRQ2:       next_field[F_IRQ2] = lo; // R1 R16
                `RIS_ADDR_TIMER_CLK:  next_field[F_T2]   = lo; // R3
                `RIS_ADDR_CAPTURE_12: next_field[F_IC1]  = lo; // R4
                `RIS_ADDR_CAPTURE_78: next_field[F_IC7]  = lo; // R5
                `RIS_ADDR_CMP_FAULT:  next_field[F_OCF]  = lo; // R6 R16
                `RIS_ADDR_PWM1_FAULT: next_field[F_PF1]  = lo; // R7 R16
                `RIS_ADDR_PWM2_FAULT: next_field[F_PF2]  = lo; // R8 R16
                `RIS_ADDR_QUADRATURE: next_field[F_QEA]  = lo; // R10
                default: ;
            endcase
        end
        if (sel_wr && lane1) begin
            case (wb_adr_in)
                `RIS_ADDR_TIMER_CLK:  next_field[F_T3]   = hi; // R2
                `RIS_ADDR_CAPTURE_12: next_field[F_IC2]  = hi; // R4
                `RIS_ADDR_CAPTURE_78: next_field[F_IC8]  = hi; // R5
                `RIS_ADDR_QUADRATURE: next_field[F_QEB]  = hi; // R9
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage; shadows copy each next value without the upset flip, so an upset shows

    integer j;
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            for (j = 0; j < NFIELD; j = j + 1) begin
                sel_field[j] <= `RIS_SEL_RESET; // R15
                shadow[j]    <= `RIS_SEL_RESET;
            end
            pin_select_lock <= `RIS_LOCK_RESET;
        end else begin
            for (j = 0; j < NFIELD; j = j + 1) begin
                sel_field[j] <= next_field[j];
                shadow[j]    <= next_field[j];
            end
            // Test hook: flips bit 0 of the first field behind the shadow
            if (upset_in) begin
                sel_field[F_IRQ2] <= next_field[F_IRQ2] ^ 5'h01;
            end
            // Unlock key sequence is software's job, kept by the clock block
            if (wr && lane0 && wb_adr_in == `RIS_ADDR_LOCK) begin
                pin_select_lock <= wb_dat_in[0]; // R18
            end
        end
    end

    // Mismatch request holds until reset clears it
    integer m;
    reg differ;
    always @* begin
        differ = 1'b0;
        for (m = 0; m < NFIELD; m = m + 1) begin
            if (sel_field[m] != shadow[m]) begin
                differ = 1'b1; // R19
            end
        end
    end

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            mismatch_reset_out <= 1'b0;
        end else if (differ) begin
            mismatch_reset_out <= 1'b1; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer: registered ack one cycle after the request, unmapped reads return zero

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
        end else begin
            wb_ack_out <= req;
            wb_dat_out <= 32'h0;
            if (req && !wb_we_in) begin
                case (wb_adr_in)
                    `RIS_ADDR_IRQ2:       wb_dat_out <= {27'h0, sel_field[F_IRQ2]}; // R16
                    `RIS_ADDR_TIMER_CLK:  wb_dat_out <= {19'h0, sel_field[F_T3],
                                                         3'h0, sel_field[F_T2]}; // R14
                    `RIS_ADDR_CAPTURE_12: wb_dat_out <= {19'h0, sel_field[F_IC2],
                                                         3'h0, sel_field[F_IC1]}; // R14
                    `RIS_ADDR_CAPTURE_78: wb_dat_out <= {19'h0, sel_field[F_IC8],
                                                         3'h0, sel_field[F_IC7]}; // R14
                    `RIS_ADDR_CMP_FAULT:  wb_dat_out <= {27'h0, sel_field[F_OCF]}; // R16
                    `RIS_ADDR_PWM1_FAULT: wb_dat_out <= {27'h0, sel_field[F_PF1]}; // R16
                    `RIS_ADDR_PWM2_FAULT: wb_dat_out <= {27'h0, sel_field[F_PF2]}; // R16
                    `RIS_ADDR_QUADRATURE: wb_dat_out <= {19'h0, sel_field[F_QEB],
                                                         3'h0, sel_field[F_QEA]}; // R14
                    `RIS_ADDR_LOCK:       wb_dat_out <= {31'h0, pin_select_lock};
                    `RIS_ADDR_STATUS:     wb_dat_out <= {31'h0, mismatch_reset_out};
                    default:              wb_dat_out <= 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Routing; mux is combinational so a pin reaches its peripheral at once

    genvar g;
    generate
        for (g = 0; g < NFIELD; g = g + 1) begin : g_mux
            ris_pin_mux #(
                .NUM_PINS (NUM_PINS)
            ) u_mux (
                .sel_in   (sel_field[g]),
                .pins_in  (remappable_pin_in),
                .peri_out (peri[g])
            );
        end
    endgenerate

    assign external_irq_two_out    = peri[F_IRQ2]; // R1
    assign timer2_ext_clock_out    = peri[F_T2];   // R3
    assign timer3_ext_clock_out    = peri[F_T3];   // R2
    assign capture1_out            = peri[F_IC1];  // R4
    assign capture2_out            = peri[F_IC2];  // R4
    assign capture7_out            = peri[F_IC7];  // R5
    assign capture8_out            = peri[F_IC8];  // R5
    assign compare_fault_input_out = peri[F_OCF];  // R6
    assign pwm1_fault_input_out    = peri[F_PF1];  // R7
    assign pwm2_fault_input_out    = peri[F_PF2];  // R8
    assign encoder_phase_a_out     = peri[F_QEA];  // R10
    assign encoder_phase_b_out     = peri[F_QEB];  // R9

endmodule // ris_input_selectors

`default_nettype wire

// *** sim/ris_pin_model.sv ***
// Board-side model of the remappable pins feeding the selector bank.
// Assumes the pins arrive already synchronised to the system clock.
`timescale 1ns/1ps
`default_nettype none
module ris_pin_model #(
    parameter NUM_PINS = 26
) (
    input  wire logic                clk_in,   // System clock
    input  wire logic [NUM_PINS-1:0] level_in, // Levels the board presents
    output var  logic [NUM_PINS-1:0] pin_out   // Pin levels into the bank
);
    // Levels move only on the clock edge, so no pin races a check
    always @(posedge clk_in) pin_out <= level_in;
endmodule // ris_pin_model
`default_nettype wire

// *** sim/ris_input_selectors_properties.sv ***
// Port checker for the input selector bank, bound from the testbench.
// Assumes one clock and a master keeping the classic bus handshake.
`timescale 1ns/1ps
`default_nettype none
module ris_selector_checker #(
    parameter NUM_PINS = 26
) (
    input wire logic        clk_sys_in,           // System clock
    input wire logic        rst_n_in,             // Sync reset
    input wire logic        wb_cyc_in,            // Cycle
    input wire logic        wb_stb_in,            // Strobe
    input wire logic [7:0]  wb_adr_in,            // Address
    input wire logic [31:0] wb_dat_out,           // Read data
    input wire logic        wb_ack_out,           // Acknowledge
    input wire logic        upset_in,             // Fault injection
    input wire logic        external_irq_two_out, // Interrupt two
    input wire logic        timer2_ext_clock_out, // Timer 2 clock
    input wire logic        pwm1_fault_input_out, // PWM1 fault
    input wire logic        encoder_phase_b_out,  // Encoder B
    input wire logic        mismatch_reset_out    // Mismatch request
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    ack_latency_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_stb_in)) else $error("ack unasked");
    data_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data outside ack");
    spare_bits_a: assert property (wb_ack_out |-> wb_dat_out[31:13] == 0 && wb_dat_out[7:5] == 0)
        else $error("spare bits not zero");
    single_field_a: assert property (wb_ack_out && (wb_adr_in == 8'h00 || wb_adr_in == 8'h10
        || wb_adr_in == 8'h14 || wb_adr_in == 8'h18) |-> wb_dat_out[15:5] == 0)
        else $error("single field upper bits set");
    unmapped_read_a: assert property (wb_ack_out && wb_adr_in > 8'h24 |-> wb_dat_out == 0)
        else $error("unmapped read not zero");
    reset_ground_a: assert property ($rose(rst_n_in) |-> !(external_irq_two_out
        || timer2_ext_clock_out || pwm1_fault_input_out || encoder_phase_b_out))
        else $error("input not grounded after reset");
    mismatch_hold_a: assert property (mismatch_reset_out |=> mismatch_reset_out)
        else $error("mismatch request dropped");
    upset_flag_a: assert property (upset_in |-> ##[1:4] mismatch_reset_out)
        else $error("upset not flagged");
endmodule // ris_selector_checker
`default_nettype wire

// *** sim/ris_input_selectors_test.sv ***
// Self-checking bench for the input selector bank over classic Wishbone.
// Assumes the pin model, the checker and the bank are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module ris_input_selectors_test;
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, upset = 1'b0, ack, mism;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [25:0] lvl = 26'h3FFFFFF, pins;
    logic [11:0] outs;
    logic [7:0]  adr_t [12] = '{8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h0C, 8'h10,
                                8'h14, 8'h18, 8'h1C, 8'h1C};
    logic [11:0] hi = 12'h854, single = 12'h381;
    int          errors = 0, cmp_count = 0, i, c, p;
    ris_pin_model #(.NUM_PINS(26)) pin_src (.clk_in(clk_sys_in), .level_in(lvl), .pin_out(pins));
    ris_input_selectors #(.NUM_PINS(26)) dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .remappable_pin_in(pins),
        .upset_in(upset), .external_irq_two_out(outs[0]), .timer2_ext_clock_out(outs[1]),
        .timer3_ext_clock_out(outs[2]), .capture1_out(outs[3]), .capture2_out(outs[4]),
        .capture7_out(outs[5]), .capture8_out(outs[6]), .compare_fault_input_out(outs[7]),
        .pwm1_fault_input_out(outs[8]), .pwm2_fault_input_out(outs[9]),
        .encoder_phase_a_out(outs[10]), .encoder_phase_b_out(outs[11]),
        .mismatch_reset_out(mism));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
        do @(posedge clk_sys_in); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        errors++;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        for (i = 0; i < 12; i++) begin
            wb(1'b0, adr_t[i], 4'hF, 32'h0, q);
            check("reset value", q, single[i] ? 32'h1F : 32'h1F1F);
            check("grounded", outs[i], 32'h0);
        end
        for (i = 0; i < 12; i++)
            for (c = 0; c < 32; c++) begin
                // Same code in both bytes: the lane select alone decides the field
                wb(1'b1, adr_t[i], hi[i] ? 4'h2 : 4'h1, {16'hFFFF, 3'h7, c[4:0], 3'h7, c[4:0]}, q);
                wb(1'b0, adr_t[i], 4'hF, 32'h0, q);
                check("field", q, single[i] ? c : hi[i] ? {c[4:0], 3'h0, 5'h1F} : {5'h1F, 3'h0, c[4:0]});
                for (p = 0; p < 2; p++) begin
                    lvl <= (c < 26 ? 26'h1 << c : 26'h3FFFFFF) ^ {26{p[0]}};
                    repeat (2) @(posedge clk_sys_in);
                    check("route", outs[i], c < 26 && p == 0);
                end
            end
        wb(1'b1, 8'h28, 4'hF, 32'hFFFFFFFF, q);
        wb(1'b0, 8'h28, 4'hF, 32'h0, q);
        check("unmapped", q, 32'h0);
        wb(1'b1, 8'h20, 4'h1, 32'h1, q);
        wb(1'b1, 8'h00, 4'h1, 32'h0, q);
        wb(1'b0, 8'h00, 4'hF, 32'h0, q);
        check("locked write", q, 32'h1F);
        wb(1'b1, 8'h20, 4'h1, 32'h0, q);
        upset <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        upset <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        check("mismatch", mism, 32'h1);
        wb(1'b0, 8'h24, 4'hF, 32'h0, q);
        check("status", q, 32'h1);
        rst_n_in <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        @(posedge clk_sys_in);
        check("mismatch cleared", mism, 32'h0);
        end_of_test;
    end
endmodule // ris_input_selectors_test
bind ris_input_selectors ris_selector_checker #(.NUM_PINS(NUM_PINS)) chk (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .upset_in(upset_in), .external_irq_two_out(external_irq_two_out),
    .timer2_ext_clock_out(timer2_ext_clock_out), .pwm1_fault_input_out(pwm1_fault_input_out),
    .encoder_phase_b_out(encoder_phase_b_out), .mismatch_reset_out(mismatch_reset_out));
`default_nettype wire
